// *** hdl/ecr_router.sv ***
// event channel router with per-channel filters, quadrature decoder and axi4-lite registers
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ecr_map.svh"
// ****************************************
// event channel router top
// ****************************************
module ecr_router
   import ecr_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int NUM_TC = 5
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // event generators
   input wire logic i_rtc_wrap,
   input wire logic i_rtc_match,
   input wire logic [2:0] i_cmp_event,
   input wire logic i_adc_event,
   input wire logic [47:0] i_port_pins,
   input wire logic [NUM_TC*8-1:0] i_timer_events,
   // channel outputs: strobe and data per channel
   output logic [NUM_CH-1:0] o_event_strobe,
   output logic [NUM_CH-1:0] o_event_data,
   // axi4-lite slave
   input wire logic [`ECR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ECR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] mux_reg [NUM_CH];
   logic [7:0] ctrl_reg [NUM_CH];
   logic [7:0] data_reg;
   logic [7:0] strobe_reg;
   logic [NUM_CH-1:0] sw_fire_reg;
   logic [14:0] presc_reg;
   logic [1:0] phase_reg;
   logic phase_valid_reg;
   logic [NUM_CH-1:0] raw;
   logic [NUM_CH-1:0] filt;
   ecr_axi_e wr_state_reg;
   ecr_axi_e rd_state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [`ECR_ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   logic [`ECR_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic wr_lane0;
   // ****************************************
   // write channel: takes address and data in either order
   // ****************************************
   assign s_axi_awready = (wr_state_reg == ECR_AXI_IDLE) && !aw_held_reg;
   assign s_axi_wready = (wr_state_reg == ECR_AXI_IDLE) && !w_held_reg;
   assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
   assign wr_lane0 = w_held_reg ? w_strb_reg[0] : s_axi_wstrb[0];
   assign wr_fire = (wr_state_reg == ECR_AXI_IDLE) &&
      (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid);
   assign s_axi_bresp = 2'h0;
   assign s_axi_bvalid = (wr_state_reg == ECR_AXI_RESP);
   // hold whichever half arrives first until the other one shows up
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_state_reg <= ECR_AXI_IDLE;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else if (i_ce) begin
         case (wr_state_reg)
            ECR_AXI_IDLE: begin
               if (wr_fire) begin
                  wr_state_reg <= ECR_AXI_RESP;
                  aw_held_reg <= 1'b0;
                  w_held_reg <= 1'b0;
               end else begin
                  if (s_axi_awvalid && !aw_held_reg) begin
                     aw_held_reg <= 1'b1;
                     aw_addr_reg <= s_axi_awaddr;
                  end
                  if (s_axi_wvalid && !w_held_reg) begin
                     w_held_reg <= 1'b1;
                     w_data_reg <= s_axi_wdata;
                     w_strb_reg <= s_axi_wstrb;
                  end
               end
            end
            ECR_AXI_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= ECR_AXI_IDLE;
               end
            end
            default: wr_state_reg <= ECR_AXI_IDLE;
         endcase
      end
   end
   // ****************************************
   // register writes; unmapped writes are ignored and answer okay
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            mux_reg[i] <= `ECR_MUX_RESET;
            ctrl_reg[i] <= `ECR_CTRL_RESET;
         end
         data_reg <= 8'h00;
         strobe_reg <= 8'h00;
      end else if (i_ce && wr_fire && wr_lane0) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_addr == 8'((`ECR_IDX_MUX0 + i) * 4)) begin
               mux_reg[i] <= wr_data[7:0];
            end
            if (wr_addr == 8'((`ECR_IDX_CTRL0 + i) * 4)) begin
               // bit 7 reserved; odd channels keep the index bits but have no decode enable
               ctrl_reg[i] <= (i % 2 == 0) ? {1'b0, wr_data[6:0]} :
                  {1'b0, wr_data[6:4], 1'b0, wr_data[2:0]};
            end
         end
         if (wr_addr == (`ECR_IDX_DATA << 2)) begin
            data_reg <= wr_data[7:0];
         end
         if (wr_addr == (`ECR_IDX_STROBE << 2)) begin
            strobe_reg <= wr_data[7:0];
         end
      end
   end
   // a strobe write fires channels whose strobe or data bit is set, for one cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sw_fire_reg <= '0;
      end else if (i_ce) begin
         if (wr_fire && wr_lane0 && wr_addr == (`ECR_IDX_STROBE << 2)) begin
            sw_fire_reg <= wr_data[NUM_CH-1:0] | data_reg[NUM_CH-1:0];
         end else begin
            sw_fire_reg <= '0;
         end
      end
   end
   // ****************************************
   // read channel: one cycle from address to data
   // ****************************************
   assign s_axi_arready = (rd_state_reg == ECR_AXI_IDLE);
   assign s_axi_rvalid = (rd_state_reg == ECR_AXI_RESP);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_state_reg <= ECR_AXI_IDLE;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (i_ce) begin
         case (rd_state_reg)
            ECR_AXI_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state_reg <= ECR_AXI_RESP;
                  s_axi_rresp <= 2'h0;
                  s_axi_rdata <= 32'h0;
                  for (int i = 0; i < NUM_CH; i++) begin
                     if (s_axi_araddr == 8'((`ECR_IDX_MUX0 + i) * 4)) begin
                        s_axi_rdata <= {24'h0, mux_reg[i]};
                     end
                     if (s_axi_araddr == 8'((`ECR_IDX_CTRL0 + i) * 4)) begin
                        s_axi_rdata <= {24'h0, ctrl_reg[i]};
                     end
                  end
                  if (s_axi_araddr == (`ECR_IDX_STROBE << 2)) begin
                     s_axi_rdata <= {24'h0, strobe_reg};
                  end else if (s_axi_araddr == (`ECR_IDX_DATA << 2)) begin
                     s_axi_rdata <= {24'h0, data_reg};
                  end
               end
            end
            ECR_AXI_RESP: begin
               if (s_axi_rready) begin
                  rd_state_reg <= ECR_AXI_IDLE;
               end
            end
            default: rd_state_reg <= ECR_AXI_IDLE;
         endcase
      end
   end
   // ****************************************
   // prescaler: bit m toggles at clock / 2^(m+1), a pulse every 2^m cycles
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         presc_reg <= 15'h0000;
      end else if (i_ce) begin
         presc_reg <= presc_reg + 15'h0001;
      end
   end
   // ****************************************
   // per-channel selector and filter
   // ****************************************
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic [7:0] sel;
         logic [2:0] cnt_reg;
         logic last_reg;
         logic [2:0] tc_idx;
         logic [3:0] nib;
         assign sel = mux_reg[c];
         assign nib = sel[7:4];
         assign tc_idx = (nib == `ECR_NIB_TC_LO) ? {2'b00, sel[3]} :
            3'(nib - `ECR_NIB_TC_LO) + 3'h1;
         // source selection; reserved and absent codes route nothing
         always_comb begin
            raw[c] = 1'b0;
            if (sel == `ECR_SEL_RTC_OVF) begin
               raw[c] = i_rtc_wrap;
            end else if (sel == `ECR_SEL_RTC_CMP) begin
               raw[c] = i_rtc_match;
            end else if (sel >= `ECR_SEL_AC_CH0 && sel <= `ECR_SEL_AC_WIN) begin
               raw[c] = i_cmp_event[sel[1:0]];
            end else if (sel == `ECR_SEL_ADC) begin
               raw[c] = i_adc_event;
            end else if (nib >= `ECR_NIB_PORT_LO && nib <= `ECR_NIB_PORT_HI) begin
               // level sources pass through every cycle they stay active
               raw[c] = i_port_pins[{nib[1:0] - 2'b01, sel[3], sel[2:0]}];
            end else if (nib == `ECR_NIB_PRESC) begin
               // one-cycle pulse every 2^m cycles; m=0 fires every cycle
               raw[c] = (sel[3:0] == 4'h0) ? 1'b1 :
                  (presc_reg & ((15'h0001 << sel[3:0]) - 15'h0001)) == 15'h0000;
            end else if (nib >= `ECR_NIB_TC_LO && (!sel[3] || nib == `ECR_NIB_TC_LO)) begin
               // types 2 and 3 reserved; C,D absent on the second timer
               if (sel[2:1] != 2'b01 && !(sel[3] && sel[2:1] == 2'b11) &&
                  int'(tc_idx) < NUM_TC) begin
                  raw[c] = i_timer_events[8 * int'(tc_idx) + int'(sel[2:0])];
               end
            end
         end
         // filter: stable sample run of length field+1; field 0 passes at once
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               cnt_reg <= 3'h0;
               last_reg <= 1'b0;
            end else if (i_ce) begin
               last_reg <= raw[c];
               if (raw[c] != last_reg) begin
                  cnt_reg <= 3'h0;
               end else if (cnt_reg != 3'h7) begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
         end
         // length 1 is the raw sample; longer lengths need the stable run
         assign filt[c] = (ctrl_reg[c][2:0] == 3'h0) ? raw[c] :
            (raw[c] && raw[c] == last_reg && cnt_reg >= ctrl_reg[c][2:0] - 3'h1);
      end
   endgenerate
   // ****************************************
   // quadrature decoder on channel 0, index from channel 1
   // ****************************************
   logic [1:0] phase_now;
   logic qd_en;
   logic idx_en;
   logic idx_hit;
   ecr_qev_e qev;
   assign qd_en = ctrl_reg[0][`ECR_CTRL_QUAD_DECODE_ENABLE_BIT];
   // phase zero is channel 0 source pin, phase ninety the next pin up
   always_comb begin
      phase_now = 2'b00;
      if (mux_reg[0][7:4] >= `ECR_NIB_PORT_LO && mux_reg[0][7:4] <= `ECR_NIB_PORT_HI) begin
         // low-level sensed pins: the phase level is the inverse of the pin
         phase_now = {~i_port_pins[{mux_reg[0][5:4] - 2'b01, mux_reg[0][3:0]}],
            ~i_port_pins[6'({mux_reg[0][5:4] - 2'b01, mux_reg[0][3:0]}) + 6'h01]};
      end
   end
   assign idx_en = ctrl_reg[1][`ECR_CTRL_INDEX_SOURCE_ENABLE_BIT];
   assign idx_hit = idx_en && filt[1] &&
      phase_now == ctrl_reg[1][`ECR_CTRL_INDEX_STATE_SELECT_LSB +: 2];
   // gray sequence 00,01,11,10 is forward (ninety leads zero)
   always_comb begin
      qev = ECR_QEV_NONE;
      if (phase_valid_reg && phase_now != phase_reg) begin
         case ({phase_reg, phase_now})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: qev = ECR_QEV_UP;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: qev = ECR_QEV_DOWN;
            default: qev = ECR_QEV_NONE; // double step is dropped
         endcase
      end
      if (idx_hit && qev == ECR_QEV_NONE) begin
         qev = ECR_QEV_INDEX;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_reg <= 2'b00;
         phase_valid_reg <= 1'b0;
      end else if (i_ce) begin
         if (qd_en) begin
            phase_reg <= phase_now;
            phase_valid_reg <= 1'b1;
         end else begin
            phase_valid_reg <= 1'b0;
         end
      end
   end
   // ****************************************
   // channel outputs, registered: one cycle of latency
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event_strobe <= '0;
         o_event_data <= '0;
      end else if (i_ce) begin
         for (int i = 0; i < NUM_CH; i++) begin
            // software events override the selector for their cycle
            if (sw_fire_reg[i]) begin
               o_event_strobe[i] <= strobe_reg[i];
               o_event_data[i] <= data_reg[i];
            end else if (i == 0 && qd_en) begin
               o_event_strobe[i] <= qev[1];
               o_event_data[i] <= qev[0];
            end else begin
               o_event_strobe[i] <= filt[i];
               o_event_data[i] <= 1'b0;
            end
         end
      end
   end

endmodule

// *** hdl/ecr_map.svh ***
// register offsets, field positions, reset values and code points of the event channel router
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH
// register indices; a register's byte address is four times its index
`define ECR_IDX_MUX0 8'h00
`define ECR_IDX_CTRL0 8'h08
`define ECR_IDX_STROBE 8'h10
`define ECR_IDX_DATA 8'h11
`define ECR_ADDR_W 8
// control fields
`define ECR_CTRL_FILT_LSB 0
`define ECR_CTRL_QUAD_DECODE_ENABLE_BIT 3
`define ECR_CTRL_INDEX_SOURCE_ENABLE_BIT 4
`define ECR_CTRL_INDEX_STATE_SELECT_LSB 5
`define ECR_MUX_RESET 8'h00
`define ECR_CTRL_RESET 8'h00
// selector code points
`define ECR_SEL_RTC_OVF 8'h08
`define ECR_SEL_RTC_CMP 8'h09
`define ECR_SEL_AC_CH0 8'h10
`define ECR_SEL_AC_CH1 8'h11
`define ECR_SEL_AC_WIN 8'h12
`define ECR_SEL_ADC 8'h20
`define ECR_NIB_PORT_LO 4'h5
`define ECR_NIB_PORT_HI 4'h7
`define ECR_NIB_PRESC 4'h8
`define ECR_NIB_TC_LO 4'hC
`define ECR_NIB_TC_HI 4'hF
// time from an event being generated to its action, in cycles
`define ECR_LAT_MAX_NS 80
`define ECR_CLK_NS 40
`define ECR_LAT_CYCLES (`ECR_LAT_MAX_NS / `ECR_CLK_NS)
`endif

// *** hdl/ecr_pkg.sv ***
// types shared by the event channel router
package ecr_pkg;
   typedef enum logic [1:0] {
      ECR_AXI_IDLE = 2'b00,
      ECR_AXI_RESP = 2'b01
   } ecr_axi_e;
   typedef enum logic [1:0] {
      ECR_QEV_NONE = 2'b00,
      ECR_QEV_INDEX = 2'b01,
      ECR_QEV_DOWN = 2'b10,
      ECR_QEV_UP = 2'b11
   } ecr_qev_e;
endpackage

// *** testbench/ecr_router_sva.sv ***
// bus-side assertions and covers, plus one channel-output cover, for the event channel router
`timescale 1ns/10ps
module ecr_router_sva #(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // write side
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel outputs
   input wire logic [NUM_CH-1:0] o_event_strobe
);
   // ****************************************
   // assertions
   // ****************************************
   // one domain only, so clock and disable are given once
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_ready_after_reset:
      assert property ($fell(i_rst) |-> s_axi_awready && s_axi_wready && s_axi_arready)
      else $error("bus not ready after reset");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> s_axi_bvalid) else $error("write response late");
   a_bvalid_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_bvalid_drops:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_write_refused:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_refused:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_rdata_stable:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved before taken");
   a_resp_okay:
      assert property ((s_axi_bvalid -> s_axi_bresp == 2'h0) &&
         (s_axi_rvalid -> s_axi_rresp == 2'h0)) else $error("response not okay");
   a_rdata_narrow:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   // covers of the main traffic
   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (s_axi_rvalid && s_axi_rready);
   c_event_out: cover property ($rose(o_event_strobe[0]));
endmodule

// *** testbench/ecr_encoder_model.sv ***
// generator-side model: a quadrature encoder on two adjacent port pins
`timescale 1ns/10ps
module ecr_encoder_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // step command
   input wire logic i_step,
   input wire logic i_fwd,
   // pin levels: [0] zero-degree pin, [1] ninety-degree pin beside it
   output logic [1:0] o_phase
);
   logic [1:0] pos_reg;
   // one quarter step per command, changed just after the edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pos_reg <= 2'h0;
      end else if (i_step) begin
         pos_reg <= i_fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
      end
   end
   // gray order so only one pin moves per step; forward lets ninety lead
   assign o_phase = {pos_reg[1] ^ pos_reg[0], pos_reg[1]};
endmodule

// *** testbench/test_ecr_router.sv ***
// self-checking bench for the event channel router
`timescale 1ns/10ps
`include "ecr_map.svh"
module test_ecr_router;
   import ecr_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   localparam int NUM_CH = 4;
   logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
   logic i_rtc_wrap = 1'b0, i_rtc_match = 1'b0, i_adc_event = 1'b0;
   logic [2:0] i_cmp_event = 3'h0;
   logic [47:0] rnd_pins = 48'h0, i_port_pins;
   logic [39:0] i_timer_events = 40'h0;
   logic [1:0] enc_phase;
   logic enc_step = 1'b0, enc_fwd = 1'b0;
   logic [3:0] o_event_strobe, o_event_data, sw_s, sw_d;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [1:0] seen [4];
   int miscompares = 0, n_compared = 0, cnt, win, n_up = 0, n_down = 0, n_idx = 0;
   int hit [4];
   int pm [3] = '{0, 3, 15};
   bit q_on = 1'b0;
   logic e;
   always #20 i_clk = ~i_clk;
   // encoder pins sit on port A pins 0 and 1, at rest they add nothing
   assign i_port_pins = rnd_pins ^ {46'h0, enc_phase};
   ecr_encoder_model ecr_encoder_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_step(enc_step),
      .i_fwd(enc_fwd), .o_phase(enc_phase));
   ecr_router #(.NUM_CH(NUM_CH), .NUM_TC(5)) ecr_router_i (.i_clk(i_clk), .i_rst(i_rst),
      .i_ce(i_ce), .i_rtc_wrap(i_rtc_wrap), .i_rtc_match(i_rtc_match),
      .i_cmp_event(i_cmp_event), .i_adc_event(i_adc_event), .i_port_pins(i_port_pins),
      .i_timer_events(i_timer_events), .o_event_strobe(o_event_strobe),
      .o_event_data(o_event_data), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] mux_addr(input int n);
      return 8'((`ECR_IDX_MUX0 + n) * 4);
   endfunction
   function automatic logic [7:0] ctrl_addr(input int n);
      return 8'((`ECR_IDX_CTRL0 + n) * 4);
   endfunction
   // reference routing of one selector code from the present generator levels
   function automatic logic route_bit(input logic [7:0] c);
      int t;
      logic [2:0] ty;
      ty = c[2:0];
      t = (c[7:4] == 4'hC) ? int'(c[3]) : int'(c[7:4]) - 11;
      case (c[7:4])
         4'h0: return (c == 8'h08) ? i_rtc_wrap : (c == 8'h09) ? i_rtc_match : 1'b0;
         4'h1: return (c[3:0] < 4'h3) ? i_cmp_event[c[1:0]] : 1'b0;
         4'h2: return (c[3:0] == 4'h0) ? i_adc_event : 1'b0;
         4'h5, 4'h6, 4'h7: return i_port_pins[(int'(c[7:4]) - 5) * 16 + int'(c[3:0])];
         4'hC, 4'hD, 4'hE, 4'hF: begin
            if ((c[3] && c[7:4] != 4'hC) || ty[2:1] == 2'b01 || (t == 1 && ty[2:1] == 2'b11)) begin
               return 1'b0;
            end
            return i_timer_events[t * 8 + int'(ty)];
         end
         default: return 1'b0;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // both halves offered together, each released as it is taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_d, w_d;
      @(posedge i_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_d = 1'b0;
      w_d = 1'b0;
      while (!(aw_d && w_d)) begin
         @(posedge i_clk);
         if (!aw_d && s_axi_awready === 1'b1) begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready === 1'b1) begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge i_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge i_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      // accept a cycle late so the slave must hold its read data
      @(posedge i_clk);
      s_axi_rready <= 1'b1;
      do @(posedge i_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // decoder output tally on channel 0
   always @(negedge i_clk) begin
      if (q_on && o_event_strobe[0] === 1'b1) begin
         if (o_event_data[0] === 1'b1) n_up++; else n_down++;
      end else if (q_on && o_event_data[0] === 1'b1) begin
         n_idx++;
      end
   end
   // watchdog at 90000 cycles, over twice the roughly 37000 cycles of tests
   initial begin
      #(90000 * 40);
      miscompares++;
      wrap_up();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      void'($urandom(32'h78BE));
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         axi_rd(mux_addr(n), rd); chk(rd, 32'h0);
         axi_rd(ctrl_addr(n), rd); chk(rd, 32'h0);
         win = n + 1 + 16 * n;
         axi_wr(mux_addr(n), 32'(win)); axi_rd(mux_addr(n), rd); chk(rd, 32'(win));
         axi_wr(mux_addr(n), 32'h0);
      end
      axi_wr(8'hFC, 32'hFF); axi_rd(8'hFC, rd); chk(rd, 32'h0);
      $display("test registers done");
      // every selector code except the prescaler codes 0x80-0x8F on channel 0 with random generator traffic
      for (int c = 0; c < 256; c++) begin
         if (c / 16 == 8) continue;
         axi_wr(mux_addr(0), 32'(c)); axi_rd(mux_addr(0), rd); chk(rd, 32'(c));
         repeat (8) begin
            @(posedge i_clk);
            e = route_bit(8'(c));
            {i_rtc_wrap, i_rtc_match, i_adc_event, i_cmp_event} <= 6'($urandom);
            rnd_pins <= {16'($urandom), $urandom};
            i_timer_events <= {8'($urandom), $urandom};
            @(negedge i_clk);
            chk(o_event_strobe, {3'h0, e});
         end
      end
      {i_rtc_wrap, i_rtc_match, i_adc_event, i_cmp_event, rnd_pins, i_timer_events} <= '0;
      $display("test routing done");
      foreach (pm[k]) begin
         axi_wr(mux_addr(0), {28'h8, 4'(pm[k])});
         win = (pm[k] > 8) ? (1 << pm[k]) : (8 << pm[k]);
         cnt = 0;
         e = 1'b0;
         repeat (win) begin
            @(negedge i_clk);
            if (pm[k] > 0 && e && o_event_strobe[0] === 1'b1) cnt += 1000;
            e = (o_event_strobe[0] === 1'b1);
            cnt += int'(e);
         end
         chk(cnt, win >> pm[k]);
      end
      $display("test prescaler done");
      // a short burst, one low sample, then a burst one longer than the length
      axi_wr(mux_addr(0), 32'h0);
      axi_wr(mux_addr(1), 32'h20);
      for (int f = 0; f < 8; f++) begin
         axi_wr(ctrl_addr(1), 32'(f));
         cnt = 0;
         for (int i = 0; i < 2 * f + 14; i++) begin
            @(posedge i_clk);
            i_adc_event <= (i < f) || (i > f && i < 2 * f + 3);
            @(negedge i_clk);
            cnt += int'(o_event_strobe[1] === 1'b1);
         end
         chk(cnt, 2);
      end
      $display("test filter done");
      axi_wr(ctrl_addr(1), 32'h0);
      axi_wr(mux_addr(0), 32'h20);
      repeat (4) begin
         sw_d = 4'($urandom);
         sw_s = 4'($urandom);
         axi_wr(8'(`ECR_IDX_DATA * 4), {28'h0, sw_d});
         axi_wr(8'(`ECR_IDX_STROBE * 4), {28'h0, sw_s});
         for (int n = 0; n < 4; n++) hit[n] = 0;
         repeat (6) begin
            @(negedge i_clk);
            for (int n = 0; n < 4; n++) begin
               if ((o_event_strobe[n] | o_event_data[n]) === 1'b1) begin
                  hit[n]++;
                  seen[n] = {o_event_strobe[n], o_event_data[n]};
               end
            end
         end
         for (int n = 0; n < 4; n++) begin
            chk(hit[n], int'(sw_s[n] | sw_d[n]));
            if (hit[n] > 0) chk(seen[n], {sw_s[n], sw_d[n]});
         end
      end
      $display("test software events done");
      axi_wr(mux_addr(0), 32'h50);
      axi_wr(ctrl_addr(0), 32'h09);
      repeat (10) @(posedge i_clk);
      q_on = 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge i_clk);
         enc_step <= 1'b1;
         enc_fwd <= (i < 6);
         @(posedge i_clk);
         enc_step <= 1'b0;
         repeat (6) @(posedge i_clk);
         if (i == 5) chk(n_up * 100 + n_down, 600);
      end
      chk(n_up * 100 + n_down, 606);
      chk(n_idx, 0);
      // index pin on channel 1, recognised in phase state 11 (both pins low)
      axi_wr(mux_addr(1), 32'h52);
      axi_wr(ctrl_addr(1), 32'h70);
      @(posedge i_clk);
      rnd_pins <= 48'h4;
      @(posedge i_clk);
      rnd_pins <= 48'h0;
      repeat (4) @(posedge i_clk);
      chk(n_idx, 1);
      $display("test quadrature done");
      wrap_up();
   end
endmodule
bind ecr_router ecr_router_sva #(.NUM_CH(NUM_CH)) ecr_router_sva_i (.i_clk(i_clk),
   .i_rst(i_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .o_event_strobe(o_event_strobe));
